// ==== dv/uff_flow_ctrl_tb_top.sv ====
// Bench of the dual-channel FIFO flow control block.
// Assumes the remote model on the far side and Wishbone register access.
`timescale 1ns/1ps
`default_nettype none
module uff_flow_ctrl_tb_top;
	import uff_pkg::*;
	logic            clock, sysRst, cyc, stb, we, ack;
	logic [7:0]      adr, q, lastStore;
	logic [3:0]      sel;
	logic [31:0]     datI, datO;
	logic [1:0]      ctsPinN, dsrPinN, modemRtsN, modemDtrN, rxValid;
	logic [1:0]      rxStopMid, rhrRead, charTick, flowTaken, rtsPinN;
	logic [1:0]      dtrPinN, txStop, fifoEnable, fifoFlush, depth128;
	logic [1:0]      rxStore, flowValid, rxTimeout, ctsFlag, xoffFlag;
	logic [1:0][7:0] rxData, rxCount, rxTrigLevel, txTrigLevel;
	logic [1:0][7:0] rxStoreData, flowChar;
	int              errorCnt = 0, totalChecks = 0, cycles = 0;
	int              flushCnt = 0, storeCnt = 0, n;
	uff_flow_ctrl dut (
		.clock, .sys_rst(sysRst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
		.wb_dat_o(datO), .wb_ack_o(ack), .ctsPinN, .dsrPinN, .modemRtsN,
		.modemDtrN, .rxValid, .rxData, .rxCount, .rxStopMid, .rhrRead,
		.charTick, .flowTaken, .rtsPinN, .dtrPinN, .txStop, .fifoEnable,
		.fifoFlush, .depth128, .rxTrigLevel, .txTrigLevel, .rxStore,
		.rxStoreData, .flowValid, .flowChar, .rxTimeout, .ctsFlag,
		.xoffFlag
	);
	uff_remote_model remote (
		.clock, .flowValid, .flowChar, .ctsPinN, .dsrPinN, .rxValid,
		.rxData, .flowTaken
	);
	// Clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Flush pulses, stored characters and the hang limit
	always @(posedge clock) begin
		cycles++;
		if (fifoFlush[0] === 1'b1) flushCnt++;
		if (rxStore[0] === 1'b1) begin
			storeCnt++;
			lastStore = rxStoreData[0];
		end
		if (cycles == 20000) begin
			errorCnt++;
			endOfTest();
		end
	end
	task endOfTest();
		$display("checks %0d mismatches %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		totalChecks++;
		if (g !== e) begin
			errorCnt++;
			$display("FAIL %s exp %h got %h", s, e, g);
		end
	endtask
	task tk(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	// Classic Wishbone cycle; read data lands in q
	task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clock);
		{cyc, stb, we, adr, sel, datI} <= {2'b11, w, a, 4'hF, 24'h00_0000, d};
		do @(posedge clock); while (ack !== 1'b1);
		q = datO[7:0];
		{cyc, stb, we} <= 3'h0;
	endtask
	task wrA(input logic [5:0] o, input logic [7:0] d);
		xfer({2'b00, o}, 1'b1, d);
	endtask
	task setCnt(input logic [7:0] v);
		@(posedge clock);
		rxCount[0] <= v;
		tk(3);
	endtask
	task rst(input string s);
		$display("%s done %0d", s, errorCnt);
		@(posedge clock);
		sysRst <= 1'b1;
		rxCount[0] <= 8'h00;
		repeat (3) @(posedge clock);
		sysRst <= 1'b0;
	endtask
	task testRegs();
		for (logic [7:0] a = 8'h24; a < 8'h34; a += 8'h04) begin
			xfer(a, 1'b0, 8'h00);
			chk("char reset", 8'h00, q);
			xfer(a, 1'b1, 8'hA5 + a);
			xfer(a, 1'b0, 8'h00);
			chk("char write", 8'hA5 + a, q);
		end
		xfer(8'h80, 1'b1, 8'hFF);
		xfer(8'h80, 1'b0, 8'h00);
		chk("unmapped", 8'h00, q);
	endtask
	task testLegacy();
		wrA(OFF_FIFO_CTRL, 8'h31);
		tk(4);
		chk("tx level held", 8'h10, txTrigLevel[0]);
		@(posedge clock);
		modemRtsN[0] <= 1'b1;
		tk(2);
		chk("modem rts", 8'h01, rtsPinN[0]);
		wrA(OFF_ENH_FEATURE, 8'h50);
		for (int k = 0; k < 4; k++) begin
			wrA(OFF_FIFO_CTRL, {2'(k), 2'(k), 4'h1});
			tk(4);
			chk("rx level", LEGACY_RX_TRIG[k], rxTrigLevel[0]);
			chk("tx level", LEGACY_TX_TRIG[k], txTrigLevel[0]);
			chk("mode", 8'h02, {6'h00, fifoEnable[0], depth128[0]});
			setCnt(LEGACY_RX_TRIG[k] - 8'h01);
			chk("rts below", 8'h00, rtsPinN[0]);
			setCnt(LEGACY_RX_TRIG[k]);
			chk("rts pause", 8'h01, rtsPinN[0]);
			setCnt(LEGACY_RESUME[k] + 8'h01);
			chk("rts held", 8'h01, rtsPinN[0]);
			setCnt(LEGACY_RESUME[k]);
			chk("rts resume", 8'h00, rtsPinN[0]);
		end
		wrA(OFF_AUX_FEATURE, 8'h04);
		setCnt(8'h1C);
		chk("dtr pause", 8'h01, dtrPinN[0]);
		n = flushCnt;
		wrA(OFF_FIFO_CTRL, 8'h00);
		tk(4);
		chk("flush off", 8'h01, 8'(flushCnt - n));
		chk("fifo off", 8'h00, fifoEnable[0]);
	endtask
	task testExtended();
		wrA(OFF_FIFO_CTRL, 8'h01);
		tk(4);
		n = flushCnt;
		wrA(OFF_FLOW_HIGH, 8'h14);
		wrA(OFF_FLOW_LOW, 8'h05);
		wrA(OFF_TX_IRQ_LEVEL, 8'h80);
		wrA(OFF_RX_IRQ_LEVEL, 8'h01);
		tk(4);
		chk("flush size", 8'h01, 8'(flushCnt - n));
		chk("depth", 8'h01, depth128[0]);
		chk("tx level", 8'h80, txTrigLevel[0]);
		chk("rx level", 8'h01, rxTrigLevel[0]);
		wrA(OFF_ENH_FEATURE, 8'h40);
		setCnt(8'h13);
		chk("rts below", 8'h00, rtsPinN[0]);
		setCnt(8'h14);
		chk("rts high", 8'h01, rtsPinN[0]);
		setCnt(8'h06);
		chk("rts held", 8'h01, rtsPinN[0]);
		setCnt(8'h05);
		chk("rts low", 8'h00, rtsPinN[0]);
		n = flushCnt;
		for (int i = 0; i < 4; i++) wrA(OFF_TX_IRQ_LEVEL + 6'(4 * i), 8'h00);
		tk(4);
		chk("flush back", 8'h01, 8'(flushCnt - n));
		chk("depth back", 8'h00, depth128[0]);
	endtask
	task testCts();
		wrA(OFF_IRQ_ENABLE, 8'h80);
		remote.setPins(1'b1, 1'b0);
		tk(5);
		chk("cts off", 8'h00, txStop[0]);
		remote.setPins(1'b0, 1'b0);
		wrA(OFF_ENH_FEATURE, 8'h80);
		remote.setPins(1'b1, 1'b0);
		tk(5);
		chk("cts stop", 8'h01, txStop[0]);
		chk("cts flag", 8'h01, ctsFlag[0]);
		remote.setPins(1'b0, 1'b0);
		tk(5);
		chk("cts go", 8'h00, txStop[0]);
		wrA(OFF_AUX_FEATURE, 8'h04);
		remote.setPins(1'b0, 1'b1);
		tk(5);
		chk("dsr stop", 8'h01, txStop[0]);
	endtask
	task testSoft();
		wrA(OFF_PAUSE_FIRST, 8'h13);
		wrA(OFF_RESUME_FIRST, 8'h11);
		wrA(OFF_PAUSE_SECOND, 8'h24);
		wrA(OFF_RESUME_SECOND, 8'h2A);
		wrA(OFF_IRQ_ENABLE, 8'h20);
		wrA(OFF_ENH_FEATURE, 8'h02);
		n = storeCnt;
		remote.sendChar(8'h33);
		tk(2);
		chk("xoff stop", 8'h01, txStop[0]);
		chk("xoff flag", 8'h01, xoffFlag[0]);
		remote.sendChar(8'h11);
		tk(2);
		chk("xon go", 8'h00, txStop[0]);
		chk("xon flag", 8'h00, xoffFlag[0]);
		remote.sendChar(8'h41);
		tk(2);
		chk("data kept", 8'h41, lastStore);
		wrA(OFF_LINE_CTRL, 8'h03);
		wrA(OFF_ENH_FEATURE, 8'h03);
		remote.sendChar(8'h13);
		tk(2);
		chk("half pair", 8'h00, txStop[0]);
		remote.sendChar(8'h24);
		tk(2);
		chk("pair stop", 8'h01, txStop[0]);
		wrA(OFF_ENH_FEATURE, 8'h01);
		remote.sendChar(8'h2A);
		tk(2);
		chk("second go", 8'h00, txStop[0]);
		chk("stored", 8'h01, 8'(storeCnt - n));
	endtask
	task testSpecial();
		wrA(OFF_PAUSE_SECOND, 8'h7E);
		wrA(OFF_IRQ_ENABLE, 8'h20);
		wrA(OFF_ENH_FEATURE, 8'h20);
		n = storeCnt;
		remote.sendChar(8'h7E);
		tk(2);
		chk("special kept", 8'h01, 8'(storeCnt - n));
		chk("special flag", 8'h01, xoffFlag[0]);
	endtask
	task testSend();
		wrA(OFF_FIFO_CTRL, 8'h01);
		wrA(OFF_PAUSE_FIRST, 8'h13);
		wrA(OFF_RESUME_FIRST, 8'h11);
		wrA(OFF_ENH_FEATURE, 8'h08);
		remote.takeDelay = 5;
		n = remote.flowCnt;
		setCnt(8'h08);
		tk(10);
		chk("xoff sent", 8'h13, remote.lastFlow);
		remote.takeDelay = 0;
		setCnt(8'h00);
		tk(4);
		chk("xon sent", 8'h11, remote.lastFlow);
		chk("sends", 8'h02, 8'(remote.flowCnt - n));
	endtask
	task chars(input int k);
		repeat (k) begin
			@(posedge clock);
			charTick[0] <= 1'b1;
			@(posedge clock);
			charTick[0] <= 1'b0;
		end
		tk(2);
	endtask
	task testTimeout();
		wrA(OFF_FIFO_CTRL, 8'h01);
		setCnt(8'h01);
		chars(3);
		@(posedge clock);
		rhrRead[0] <= 1'b1;
		@(posedge clock);
		rhrRead[0] <= 1'b0;
		chars(3);
		chk("no timeout", 8'h00, rxTimeout[0]);
		chars(1);
		chk("timeout", 8'h01, rxTimeout[0]);
		@(posedge clock);
		rxStopMid[0] <= 1'b1;
		tk(1);
		chk("stop restart", 8'h00, rxTimeout[0]);
		xfer({2'b01, OFF_TX_IRQ_LEVEL}, 1'b1, 8'h40);
		tk(4);
		chk("B depth", 8'h02, {6'h00, depth128});
		chk("B tx level", 8'h40, txTrigLevel[1]);
	endtask
	// Main sequence, a reset before each test
	initial begin
		{cyc, stb, we, adr, sel, datI, rxCount, modemRtsN} = '0;
		{modemDtrN, rxStopMid, rhrRead, charTick} = '0;
		sysRst = 1'b1;
		rst("start");
		testRegs();
		rst("regs");
		testLegacy();
		rst("legacy");
		testExtended();
		rst("extended");
		testCts();
		rst("cts");
		testSoft();
		rst("soft");
		testSpecial();
		rst("special");
		testSend();
		rst("send");
		testTimeout();
		rst("timeout");
		endOfTest();
	end
endmodule
`default_nettype wire

// ==== dv/uff_remote_model.sv ====
// Remote serial device: flow pins, received characters, flow char taker.
// Assumes the bench clock; only channel A carries traffic.
`timescale 1ns/1ps
`default_nettype none
module uff_remote_model (
	input  wire logic            clock,
	input  wire logic [1:0]      flowValid,
	input  wire logic [1:0][7:0] flowChar,
	output logic      [1:0]      ctsPinN,
	output logic      [1:0]      dsrPinN,
	output logic      [1:0]      rxValid,
	output logic      [1:0][7:0] rxData,
	output logic      [1:0]      flowTaken
);
	int         takeDelay = 0, waitCnt = 0, flowCnt = 0;
	logic [7:0] lastFlow = 8'h00;
	// Pins start at flow on, data line scrambled
	initial begin
		{ctsPinN, dsrPinN, rxValid, flowTaken} = 8'h00;
		rxData = 16'h5AA5;
	end
	// Transmitter takes a flow char after takeDelay cycles
	always @(posedge clock) begin
		flowTaken[1] <= flowValid[1] & ~flowTaken[1];
		flowTaken[0] <= 1'b0;
		if (flowValid[0] === 1'b1 && !flowTaken[0]) begin
			if (waitCnt >= takeDelay) begin
				flowTaken[0] <= 1'b1;
				lastFlow <= flowChar[0];
				flowCnt <= flowCnt + 1;
				waitCnt <= 0;
			end else begin
				waitCnt <= waitCnt + 1;
			end
		end
	end
	// One character, then the line shows the inverse
	task sendChar(input logic [7:0] d);
		@(posedge clock);
		rxValid[0] <= 1'b1;
		rxData[0] <= d;
		@(posedge clock);
		rxValid[0] <= 1'b0;
		rxData[0] <= ~d;
		repeat (2) @(posedge clock);
	endtask
	// Flow-off request pins, 1 = stop
	task setPins(input logic c, input logic d);
		@(posedge clock);
		ctsPinN[0] <= c;
		dsrPinN[0] <= d;
	endtask
endmodule
`default_nettype wire

// ==== pkg/uff_pkg.sv ====
// Shared constants and state types of the dual-channel FIFO flow control.
// Assumes one 40 MHz clock and a classic Wishbone register port.
package uff_pkg;

	// Byte offsets inside one channel window
	localparam logic [5:0] OFF_FIFO_CTRL    = 6'h00;
	localparam logic [5:0] OFF_ENH_FEATURE  = 6'h04;
	localparam logic [5:0] OFF_IRQ_ENABLE   = 6'h08;
	localparam logic [5:0] OFF_LINE_CTRL    = 6'h0C;
	localparam logic [5:0] OFF_AUX_FEATURE  = 6'h10;
	localparam logic [5:0] OFF_TX_IRQ_LEVEL = 6'h14;
	localparam logic [5:0] OFF_RX_IRQ_LEVEL = 6'h18;
	localparam logic [5:0] OFF_FLOW_HIGH    = 6'h1C;
	localparam logic [5:0] OFF_FLOW_LOW     = 6'h20;
	localparam logic [5:0] OFF_RESUME_FIRST = 6'h24;
	localparam logic [5:0] OFF_RESUME_SECOND = 6'h28;
	localparam logic [5:0] OFF_PAUSE_FIRST  = 6'h2C;
	localparam logic [5:0] OFF_PAUSE_SECOND = 6'h30;
	localparam logic [5:0] OFF_STATUS       = 6'h34;
	localparam int CHAN_SEL_BIT = 6;
	localparam int MAP_LIMIT_BIT = 7;

	// Field positions
	localparam int FCR_ENABLE = 0;
	localparam int EFR_TXSEL_EN = 4;
	localparam int EFR_SPECIAL = 5;
	localparam int EFR_AUTO_RTS = 6;
	localparam int EFR_AUTO_CTS = 7;
	localparam int IER_XOFF = 5;
	localparam int IER_CTS = 7;
	localparam int AUX_DSR_DTR = 2;
	localparam int ST_XOFF = 4;
	localparam int ST_CTS = 5;

	// Reset value of every control register
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Legacy 32-entry tables and word-length character masks, index 0 in the low byte
	localparam logic [3:0][7:0] LEGACY_RX_TRIG = {8'h1C, 8'h18, 8'h10, 8'h08};
	localparam logic [3:0][7:0] LEGACY_TX_TRIG = {8'h1E, 8'h18, 8'h08, 8'h10};
	localparam logic [3:0][7:0] LEGACY_RESUME  = {8'h17, 8'h0F, 8'h07, 8'h00};
	localparam logic [3:0][7:0] CHAR_MASK      = {8'hFF, 8'h7F, 8'h3F, 8'h1F};

	// Receive time-out in character times
	localparam logic [2:0] TIMEOUT_CHARS = 3'h4;

	typedef enum logic [1:0] {FLOW_IDLE, FLOW_FIRST, FLOW_SECOND} uff_flow_type;

	typedef struct packed {
		logic [7:0]   fifoCtrl;
		logic [7:0]   enhFeature;
		logic [7:0]   irqEnable;
		logic [7:0]   lineCtrl;
		logic [7:0]   auxFeature;
		logic [7:0]   txIrqLevel;
		logic [7:0]   rxIrqLevel;
		logic [7:0]   flowHighCount;
		logic [7:0]   flowLowCount;
		logic [7:0]   resumeFirst;
		logic [7:0]   resumeSecond;
		logic [7:0]   pauseFirst;
		logic [7:0]   pauseSecond;
		logic [1:0]   txSel;
		logic         extPrev;
		logic [1:0]   pinS1;
		logic [1:0]   pinS2;
		logic         flowInPrev;
		logic         xoffHold;
		logic         rxPaused;
		logic         heldValid;
		logic         heldIsPause;
		logic [7:0]   heldChar;
		logic         replayValid;
		logic [7:0]   replayChar;
		logic [2:0]   toCount;
		logic         rxTimeout;
		logic         flushOut;
		logic         rtsN;
		logic         dtrN;
		logic         txStop;
		logic         rxStore;
		logic [7:0]   rxStoreData;
		logic         flowValid;
		logic [7:0]   flowChar;
		logic         flowSentPause;
		uff_flow_type flowState;
		logic [7:0]   rxTrig;
		logic [7:0]   txTrig;
		logic         depth128;
		logic         ctsFlag;
		logic         xoffFlag;
	} uff_chan_type;

	typedef struct packed {
		logic              ack;
		logic [7:0]        rdData;
		uff_chan_type [1:0] ch;
	} uff_state_type;

endpackage

// ==== verilog/uff_flow_ctrl.sv ====
// FIFO trigger levels, FIFO flush and hardware/software flow control
// for two UART channels behind one classic Wishbone slave.
// Assumes the FIFOs, serializer and baud timing sit outside on this clock;
// the flow control pins arrive asynchronously.
//
// What this block does
// - Level registers all zero: 32-entry FIFOs, legacy trigger fields.
// - FIFO enable bit turns both data FIFOs on.
// - Transmit trigger select applies only while enhanced bit 4 is set.
// - Legacy levels: receive 8/16/24/28, transmit 16/8/24/30.
// - Legacy flow pauses at 8/16/24/28, resumes at 0/7/15/23.
// - Any level register nonzero: triggers from level registers, 1 to 128.
// - Effective FIFO size change flushes both FIFOs.
// - Enhanced bit 6 enables auto request-to-send, bit 7 clear-to-send.
// - Clear-to-send rise sets status bit 5 if enabled, halts transmit until low.
// - Aux bit 2 moves flow input to DSR, output to DTR.
// - Request-to-send drops at pause level; reception continues until full.
// - Extended pause and resume fills come from flow high and low counts.
// - Pause character match halts transmit, sets status bit 4 if enabled.
// - Resume character match restarts transmit, clears status bit 4.
// - Reset clears the four flow characters; any value writable after.
// - Double mode needs two consecutive matching characters.
// - Recognised flow characters are not stored.
// - Send pause when fill reaches the pause level, resume at or below the resume level.
// - Special detect stores a second-pause match, sets status bit 4 if enabled.
// - Comparisons use the 5 to 8 low bits set by word length.
// - Receive time-out after 4 idle character times with data waiting.
`timescale 1ns/1ps
`default_nettype none

module uff_flow_ctrl (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	input  wire logic [1:0]       ctsPinN,
	input  wire logic [1:0]       dsrPinN,
	input  wire logic [1:0]       modemRtsN,
	input  wire logic [1:0]       modemDtrN,
	input  wire logic [1:0]       rxValid,
	input  wire logic [1:0][7:0]  rxData,
	input  wire logic [1:0][7:0]  rxCount,
	input  wire logic [1:0]       rxStopMid,
	input  wire logic [1:0]       rhrRead,
	input  wire logic [1:0]       charTick,
	input  wire logic [1:0]       flowTaken,
	output logic      [1:0]       rtsPinN,
	output logic      [1:0]       dtrPinN,
	output logic      [1:0]       txStop,
	output logic      [1:0]       fifoEnable,
	output logic      [1:0]       fifoFlush,
	output logic      [1:0]       depth128,
	output logic      [1:0][7:0]  rxTrigLevel,
	output logic      [1:0][7:0]  txTrigLevel,
	output logic      [1:0]       rxStore,
	output logic      [1:0][7:0]  rxStoreData,
	output logic      [1:0]       flowValid,
	output logic      [1:0][7:0]  flowChar,
	output logic      [1:0]       rxTimeout,
	output logic      [1:0]       ctsFlag,
	output logic      [1:0]       xoffFlag
);
	import uff_pkg::*;

	uff_state_type st_reg;
	uff_state_type st_next;

	logic [1:0]      ext;
	logic [1:0]      pauseNow;
	logic [1:0]      resumeNow;
	logic [1:0][7:0] rxTrigW;
	logic [1:0][7:0] txTrigW;
	logic [1:0][7:0] maskW;
	logic [1:0]      mOn1;
	logic [1:0]      mOn2;
	logic [1:0]      mOff1;
	logic [1:0]      mOff2;
	logic            busWr;
	logic            wr0Any;

	// Masked character compare
	function automatic logic charEq(input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] m);
		charEq = ((a ^ b) & m) == 8'h00;
	endfunction

	assign busWr = wb_cyc_i & wb_stb_i & ~st_reg.ack & wb_we_i & wb_sel_i[0]
		& ~wb_adr_i[MAP_LIMIT_BIT];
	assign wr0Any = busWr & ~wb_adr_i[CHAN_SEL_BIT];

	// Per-channel levels, thresholds and character matches
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gChan
			uff_chan_type c;
			assign c = st_reg.ch[g];
			assign ext[g] = |{c.txIrqLevel, c.rxIrqLevel,
				c.flowHighCount, c.flowLowCount};
			assign rxTrigW[g] = ext[g] ? c.rxIrqLevel
				: LEGACY_RX_TRIG[c.fifoCtrl[7:6]];
			assign txTrigW[g] = ext[g] ? c.txIrqLevel
				: LEGACY_TX_TRIG[c.txSel];
			assign pauseNow[g] = rxCount[g] >= (ext[g] ? c.flowHighCount
				: LEGACY_RX_TRIG[c.fifoCtrl[7:6]]);
			assign resumeNow[g] = rxCount[g] <= (ext[g] ? c.flowLowCount
				: LEGACY_RESUME[c.fifoCtrl[7:6]]);
			assign maskW[g] = CHAR_MASK[c.lineCtrl[1:0]];
			assign mOn1[g] = charEq(rxData[g], c.resumeFirst, maskW[g]);
			assign mOn2[g] = charEq(rxData[g], c.resumeSecond, maskW[g]);
			assign mOff1[g] = charEq(rxData[g], c.pauseFirst, maskW[g]);
			assign mOff2[g] = charEq(rxData[g], c.pauseSecond, maskW[g]);
			// Outputs straight from the state register
			assign rtsPinN[g] = c.rtsN;
			assign dtrPinN[g] = c.dtrN;
			assign txStop[g] = c.txStop;
			assign fifoEnable[g] = c.fifoCtrl[FCR_ENABLE];
			assign fifoFlush[g] = c.flushOut;
			assign depth128[g] = c.depth128;
			assign rxTrigLevel[g] = c.rxTrig;
			assign txTrigLevel[g] = c.txTrig;
			assign rxStore[g] = c.rxStore;
			assign rxStoreData[g] = c.rxStoreData;
			assign flowValid[g] = c.flowValid;
			assign flowChar[g] = c.flowChar;
			assign rxTimeout[g] = c.rxTimeout;
			assign ctsFlag[g] = c.ctsFlag;
			assign xoffFlag[g] = c.xoffFlag;
		end
	endgenerate

	assign wb_ack_o = st_reg.ack;
	assign wb_dat_o = {24'h00_0000, st_reg.rdData};

	// Next state of bus slave and both channels
	always_comb begin
		uff_chan_type cs;
		uff_chan_type rc;
		logic         wr;
		logic         set4;
		logic         set5;
		logic         clr4;
		logic         clr5;
		logic         hwClr4;
		logic         flowIn;
		logic         flowOut;
		logic         storeNow;
		logic [7:0]   storeChar;
		logic [1:0]   swRx;
		logic [1:0]   swTx;
		cs = '0;
		rc = '0;
		wr = 1'b0;
		set4 = 1'b0;
		set5 = 1'b0;
		clr4 = 1'b0;
		clr5 = 1'b0;
		hwClr4 = 1'b0;
		flowIn = 1'b0;
		flowOut = 1'b0;
		storeNow = 1'b0;
		storeChar = 8'h00;
		swRx = 2'b00;
		swTx = 2'b00;
		st_next = st_reg;

		// Single-cycle acknowledge, unmapped reads return zero
		st_next.ack = wb_cyc_i & wb_stb_i & ~st_reg.ack;
		rc = st_reg.ch[wb_adr_i[CHAN_SEL_BIT]];
		st_next.rdData = 8'h00;
		if (!wb_adr_i[MAP_LIMIT_BIT]) begin
			case (wb_adr_i[5:0])
				OFF_FIFO_CTRL:     st_next.rdData = rc.fifoCtrl;
				OFF_ENH_FEATURE:   st_next.rdData = rc.enhFeature;
				OFF_IRQ_ENABLE:    st_next.rdData = rc.irqEnable;
				OFF_LINE_CTRL:     st_next.rdData = rc.lineCtrl;
				OFF_AUX_FEATURE:   st_next.rdData = rc.auxFeature;
				OFF_TX_IRQ_LEVEL:  st_next.rdData = rc.txIrqLevel;
				OFF_RX_IRQ_LEVEL:  st_next.rdData = rc.rxIrqLevel;
				OFF_FLOW_HIGH:     st_next.rdData = rc.flowHighCount;
				OFF_FLOW_LOW:      st_next.rdData = rc.flowLowCount;
				OFF_RESUME_FIRST:  st_next.rdData = rc.resumeFirst;
				OFF_RESUME_SECOND: st_next.rdData = rc.resumeSecond;
				OFF_PAUSE_FIRST:   st_next.rdData = rc.pauseFirst;
				OFF_PAUSE_SECOND:  st_next.rdData = rc.pauseSecond;
				OFF_STATUS:        st_next.rdData = {2'b00, rc.ctsFlag,
					rc.xoffFlag, rc.depth128, rc.rxTimeout, rc.rtsN, rc.txStop};
				default:           st_next.rdData = 8'h00;
			endcase
		end

		for (int c = 0; c < 2; c++) begin
			cs = st_reg.ch[c];
			wr = busWr & (wb_adr_i[CHAN_SEL_BIT] == 1'(c));
			set4 = 1'b0;
			clr4 = 1'b0;
			clr5 = 1'b0;
			hwClr4 = 1'b0;
			storeNow = 1'b0;
			storeChar = rxData[c];

			// Register writes; flow characters accept any value
			if (wr) begin
				case (wb_adr_i[5:0])
					OFF_FIFO_CTRL:     cs.fifoCtrl = wb_dat_i[7:0];
					OFF_ENH_FEATURE:   cs.enhFeature = wb_dat_i[7:0];
					OFF_IRQ_ENABLE:    cs.irqEnable = wb_dat_i[7:0];
					OFF_LINE_CTRL:     cs.lineCtrl = wb_dat_i[7:0];
					OFF_AUX_FEATURE:   cs.auxFeature = wb_dat_i[7:0];
					OFF_TX_IRQ_LEVEL:  cs.txIrqLevel = wb_dat_i[7:0];
					OFF_RX_IRQ_LEVEL:  cs.rxIrqLevel = wb_dat_i[7:0];
					OFF_FLOW_HIGH:     cs.flowHighCount = wb_dat_i[7:0];
					OFF_FLOW_LOW:      cs.flowLowCount = wb_dat_i[7:0];
					OFF_RESUME_FIRST:  cs.resumeFirst = wb_dat_i[7:0];
					OFF_RESUME_SECOND: cs.resumeSecond = wb_dat_i[7:0];
					OFF_PAUSE_FIRST:   cs.pauseFirst = wb_dat_i[7:0];
					OFF_PAUSE_SECOND:  cs.pauseSecond = wb_dat_i[7:0];
					OFF_STATUS: begin
						clr4 = wb_dat_i[ST_XOFF];
						clr5 = wb_dat_i[ST_CTS];
					end
					default: ;
				endcase
			end
			swRx = st_reg.ch[c].enhFeature[1:0];
			swTx = st_reg.ch[c].enhFeature[3:2];

			// Transmit trigger select only follows while enabled
			if (st_reg.ch[c].enhFeature[EFR_TXSEL_EN]) begin
				cs.txSel = st_reg.ch[c].fifoCtrl[5:4];
			end

			// Flush on enable toggle or mode change
			cs.flushOut = (ext[c] != st_reg.ch[c].extPrev)
				| (cs.fifoCtrl[FCR_ENABLE]
				!= st_reg.ch[c].fifoCtrl[FCR_ENABLE]);
			cs.extPrev = ext[c];
			cs.depth128 = ext[c];
			cs.rxTrig = rxTrigW[c];
			cs.txTrig = txTrigW[c];

			// Receive fill hysteresis; storing is never gated here
			if (pauseNow[c]) begin
				cs.rxPaused = 1'b1;
			end else if (resumeNow[c]) begin
				cs.rxPaused = 1'b0;
			end

			// Flow input synchroniser and selection
			cs.pinS1 = {dsrPinN[c], ctsPinN[c]};
			cs.pinS2 = st_reg.ch[c].pinS1;
			flowIn = st_reg.ch[c].auxFeature[AUX_DSR_DTR]
				? st_reg.ch[c].pinS2[1] : st_reg.ch[c].pinS2[0];
			cs.flowInPrev = flowIn;
			set5 = flowIn & ~st_reg.ch[c].flowInPrev
				& st_reg.ch[c].enhFeature[EFR_AUTO_CTS]
				& st_reg.ch[c].irqEnable[IER_CTS];

			// Replay of a character that broke a double sequence
			cs.replayValid = 1'b0;
			if (st_reg.ch[c].replayValid) begin
				storeNow = 1'b1;
				storeChar = st_reg.ch[c].replayChar;
			end

			// Received character matching
			if (rxValid[c]) begin
				if (swRx == 2'b00) begin
					storeNow = 1'b1;
					cs.heldValid = 1'b0;
				end else if (swRx != 2'b11) begin
					if (swRx[1] ? mOff1[c] : mOff2[c]) begin
						cs.xoffHold = 1'b1;
						set4 = st_reg.ch[c].irqEnable[IER_XOFF];
					end else if (swRx[1] ? mOn1[c] : mOn2[c]) begin
						cs.xoffHold = 1'b0;
						hwClr4 = 1'b1;
					end else begin
						storeNow = 1'b1;
					end
				end else if (st_reg.ch[c].heldValid) begin
					cs.heldValid = 1'b0;
					if (st_reg.ch[c].heldIsPause && mOff2[c]) begin
						cs.xoffHold = 1'b1;
						set4 = st_reg.ch[c].irqEnable[IER_XOFF];
					end else if (!st_reg.ch[c].heldIsPause && mOn2[c]) begin
						cs.xoffHold = 1'b0;
						hwClr4 = 1'b1;
					end else begin
						storeNow = 1'b1;
						storeChar = st_reg.ch[c].heldChar;
						cs.replayValid = 1'b1;
						cs.replayChar = rxData[c];
					end
				end else if (mOff1[c] || mOn1[c]) begin
					cs.heldValid = 1'b1;
					cs.heldIsPause = mOff1[c];
					cs.heldChar = rxData[c];
				end else begin
					storeNow = 1'b1;
				end
			end
			if (swRx == 2'b00) begin
				cs.xoffHold = 1'b0;
			end

			// Special character still goes to the FIFO
			if (storeNow && st_reg.ch[c].enhFeature[EFR_SPECIAL]
				&& charEq(storeChar, st_reg.ch[c].pauseSecond, maskW[c])) begin
				set4 = set4 | st_reg.ch[c].irqEnable[IER_XOFF];
			end
			cs.rxStore = storeNow;
			cs.rxStoreData = storeChar;

			// Sticky status, set wins over clear
			cs.xoffFlag = (st_reg.ch[c].xoffFlag & ~clr4 & ~hwClr4) | set4;
			cs.ctsFlag = (st_reg.ch[c].ctsFlag & ~clr5) | set5;

			// Transmit halt from selected flow input (clear-to-send or DSR) or pause character
			cs.txStop = (flowIn & st_reg.ch[c].enhFeature[EFR_AUTO_CTS])
				| cs.xoffHold;

			// Receive time-out over character ticks
			if (rxStopMid[c] || rhrRead[c] || rxCount[c] == 8'h00) begin
				cs.toCount = 3'h0;
				cs.rxTimeout = 1'b0;
			end else if (charTick[c] && st_reg.ch[c].toCount != TIMEOUT_CHARS) begin
				cs.toCount = st_reg.ch[c].toCount + 3'h1;
				cs.rxTimeout = (st_reg.ch[c].toCount + 3'h1) == TIMEOUT_CHARS;
			end

			// Pause/resume character sender
			case (st_reg.ch[c].flowState)
				FLOW_IDLE: begin
					if (swTx != 2'b00
						&& st_reg.ch[c].rxPaused != st_reg.ch[c].flowSentPause) begin
						cs.flowSentPause = st_reg.ch[c].rxPaused;
						cs.flowState = FLOW_FIRST;
						cs.flowValid = 1'b1;
						if (st_reg.ch[c].rxPaused) begin
							cs.flowChar = (swTx == 2'b01) ? st_reg.ch[c].pauseSecond
								: st_reg.ch[c].pauseFirst;
						end else begin
							cs.flowChar = (swTx == 2'b01) ? st_reg.ch[c].resumeSecond
								: st_reg.ch[c].resumeFirst;
						end
					end
				end
				FLOW_FIRST: begin
					if (flowTaken[c] && swTx == 2'b11) begin
						cs.flowState = FLOW_SECOND;
						cs.flowChar = st_reg.ch[c].flowSentPause
							? st_reg.ch[c].pauseSecond : st_reg.ch[c].resumeSecond;
					end else if (flowTaken[c]) begin
						cs.flowState = FLOW_IDLE;
						cs.flowValid = 1'b0;
					end
				end
				FLOW_SECOND: begin
					if (flowTaken[c]) begin
						cs.flowState = FLOW_IDLE;
						cs.flowValid = 1'b0;
					end
				end
				default: begin
					cs.flowState = FLOW_IDLE;
					cs.flowValid = 1'b0;
				end
			endcase

			// Request-to-send or terminal-ready output
			flowOut = st_reg.ch[c].enhFeature[EFR_AUTO_RTS] ? cs.rxPaused
				: (cs.auxFeature[AUX_DSR_DTR] ? modemDtrN[c] : modemRtsN[c]);
			cs.rtsN = cs.auxFeature[AUX_DSR_DTR] ? modemRtsN[c] : flowOut;
			cs.dtrN = cs.auxFeature[AUX_DSR_DTR] ? flowOut : modemDtrN[c];
			st_next.ch[c] = cs;
		end
	end

	// State register, all zero after reset
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sequence s_fcr_write;
		busWr && !wb_adr_i[CHAN_SEL_BIT] && wb_adr_i[5:0] == OFF_FIFO_CTRL;
	endsequence

	sequence s_cts_rise;
		st_reg.ch[0].enhFeature[EFR_AUTO_CTS] && !st_reg.ch[0].auxFeature[2]
			&& !st_reg.ch[0].pinS2[0] ##1 st_reg.ch[0].pinS2[0];
	endsequence

	a_wb_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack long");
	a_fifo_enable_follows: assert property (s_fcr_write |=> ##1
		fifoEnable[0] == $past(wb_dat_i[0], 2))
		else $error("enable lost");
	a_tx_select_held: assert property (
		!st_reg.ch[0].enhFeature[EFR_TXSEL_EN] |=> $stable(st_reg.ch[0].txSel))
		else $error("tx select moved");
	a_legacy_rx_level: assert property (!ext[0] |=>
		rxTrigLevel[0] == $past(LEGACY_RX_TRIG[st_reg.ch[0].fifoCtrl[7:6]]))
		else $error("legacy rx trigger wrong");
	a_ext_rx_level: assert property (ext[0] |=>
		rxTrigLevel[0] == $past(st_reg.ch[0].rxIrqLevel) && depth128[0])
		else $error("extended rx trigger wrong");
	a_mode_flush: assert property (ext[0] != st_reg.ch[0].extPrev |=>
		fifoFlush[0])
		else $error("no flush");
	a_cts_halt_flag: assert property (s_cts_rise |=> txStop[0]
		&& (ctsFlag[0] || !$past(st_reg.ch[0].irqEnable[IER_CTS])))
		else $error("cts rise not handled");
	a_rts_pause: assert property (st_reg.ch[0].enhFeature[EFR_AUTO_RTS]
		&& !st_reg.ch[0].auxFeature[2] && !wr0Any && pauseNow[0]
		|=> rtsPinN[0])
		else $error("rts not off");
	a_xoff_single: assert property (rxValid[0] &&
		st_reg.ch[0].enhFeature[1:0] == 2'b10 && mOff1[0] |=> txStop[0]
		&& !rxStore[0])
		else $error("pause ignored");
	a_xon_single: assert property (rxValid[0] && !mOff1[0]
		&& st_reg.ch[0].enhFeature[1:0] == 2'b10 && mOn1[0]
		&& !st_reg.ch[0].pinS2[0] && !wr0Any |=> !xoffFlag[0])
		else $error("resume ignored");
	a_timeout_empty: assert property (rxCount[0] == 8'h00 |=> !rxTimeout[0])
		else $error("timeout when empty");

endmodule

`default_nettype wire
